/* File: src/rsb_field_bus_regs.sv */
// Register bank behind the RS485 field-bus protocol engine of a room sensor.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_field_bus_cfg.svh"

// Function
// [RQ1] All switches zero selects the stored address.
// [RQ2] Modbus stored address defaults 45, accepts 1..247.
// [RQ3] BACnet stored address accepts 0..127.
// [RQ4] Modbus nonzero switches win, limited to 247.
// [RQ5] BACnet nonzero switches win over stored address.
// [RQ6] BACnet ignores switch bit eight; 0x80 gives zero.
// [RQ7] BACnet link fixed 8N1, six baud choices.
// [RQ8] Modbus link parity none/odd/even, one or two stops.
// [RQ9] Single writes at 0x00 and 0x01 take effect.
// [RQ10] Serial number text at addresses 0x00..0x07.
// [RQ11] Firmware version major high, minor low.
// [RQ12] Sensor name text in eight registers.
// [RQ13] Master reads whole eight-register text fields.
// [RQ14] Master reads both float halves together.
// [RQ15] Reads answer to function 0x03 or 0x04.
// [RQ16] Protocol address is register number minus one.
// [RQ17] Status register readable at address 0x259.
// [RQ18] Measurands offered as float and int16.
// [RQ19] Temperature and humidity floats at fixed addresses.
// [RQ20] Dew point floats at fixed addresses.
// [RQ21] Critical error gives NaN and 0x8000.
// [RQ22] Switches sampled and settled before first request.
module rsb_field_bus_regs #(
	parameter logic [7:0] FW_MAJOR = 8'h01,
	parameter logic [7:0] FW_MINOR = 8'h00
)(
	// Clock and reset
	input  wire logic                         mclk,
	input  wire logic                         reset,
	// Address switches and protocol strap pins
	input  wire logic [7:0]                   dip_switch_pin,
	input  wire logic                         bacnet_mode_pin,
	// Measurement and identity sources
	input  wire rsb_field_bus_pkg::rsb_meas_t meas,
	input  wire logic [15:0]                  status_bits,
	input  wire logic                         critical_error,
	input  wire logic [127:0]                 serial_text,
	input  wire logic [127:0]                 name_text,
	// Request from the protocol engine
	input  wire rsb_field_bus_pkg::rsb_req_t  req,
	output logic                              req_ready,
	// Answer to the protocol engine
	output rsb_field_bus_pkg::rsb_rsp_t       rsp,
	// Link setup
	output logic [7:0]                        node_address,
	output rsb_field_bus_pkg::rsb_frame_t     frame,
	output logic                              bacnet_mode
);
	import rsb_field_bus_pkg::*;

	localparam logic [6:0][15:0] FLT_ADDR = {`RSB_FLT_TD_K, `RSB_FLT_TD_F,
		`RSB_FLT_TD_C, `RSB_FLT_RH, `RSB_FLT_T_K, `RSB_FLT_T_F, `RSB_FLT_T_C};
	localparam logic [6:0][15:0] FIX_ADDR = {`RSB_FIX_TD_K, `RSB_FIX_TD_F,
		`RSB_FIX_TD_C, `RSB_FIX_RH, `RSB_FIX_T_K, `RSB_FIX_T_F, `RSB_FIX_T_C};

	logic [7:0]  dip_s1_q, dip_s2_q, dip_s3_q, dip_q;
	logic        mode_s1_q, mode_s2_q, mode_s3_q, mode_q;
	logic [3:0]  settle_q;
	rsb_state_t  state_q, state_d;
	logic [15:0] ptr_q;
	logic [7:0]  left_q;
	rsb_meas_t   snap_q;
	logic [15:0] stat_snap_q;
	logic [7:0]  addr_q;
	rsb_frame_t  frame_set_q;
	logic        req_ready_q;
	rsb_rsp_t    rsp_q;
	logic [7:0]  node_address_q;
	rsb_frame_t  frame_q;
	logic        take, take_rd, take_wr, count_ok, wr_addr_ok, wr_frame_ok;
	logic [16:0] word;

	// Effective node address from switches and the stored setting.
	function automatic logic [7:0] eff_addr(input logic [7:0] dip,
		input logic [7:0] stored, input logic bac);
		if (dip == 8'h00)
			return stored;
		else if (bac)
			return {1'b0, dip[6:0]};
		else if (dip > `RSB_MB_MAX)
			return `RSB_MB_MAX;
		else
			return dip;
	endfunction : eff_addr

	// Read decode: bit 16 is the hit flag, the low bits the word.
	function automatic logic [16:0] read_word(input logic [15:0] a,
		input rsb_meas_t m, input logic [15:0] st);
		logic [16:0] r;
		logic [15:0] k;
		r = 17'h0_0000;
		k = a - `RSB_NAME_BASE;
		if (a <= `RSB_SERIAL_LAST)
			r = {1'b1, serial_text[(7 - a[2:0]) * 16 +: 16]};
		else if (a == `RSB_FW_VER)
			r = {1'b1, FW_MAJOR, FW_MINOR}; // [RQ11]
		else if (a <= `RSB_NAME_LAST)
			r = {1'b1, name_text[(7 - k[2:0]) * 16 +: 16]};
		else if (a == `RSB_STATUS)
			r = {1'b1, st};
		for (int i = 0; i < 7; i++)
		begin
			if (a == FLT_ADDR[i])
				r = {1'b1, m.flt[i][31:16]};
			else if (a == FLT_ADDR[i] + 16'h0001)
				r = {1'b1, m.flt[i][15:0]};
			else if (a == FIX_ADDR[i])
				r = {1'b1, m.fix[i]};
		end
		return r;
	endfunction : read_word

	// Pins cross in three stages; a value is taken once stages two and three agree.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			dip_s1_q  <= 8'h00;
			dip_s2_q  <= 8'h00;
			dip_s3_q  <= 8'h00;
			dip_q     <= 8'h00;
			mode_s1_q <= 1'b0;
			mode_s2_q <= 1'b0;
			mode_s3_q <= 1'b0;
			mode_q    <= 1'b0;
		end
		else
		begin
			dip_s1_q  <= dip_switch_pin;
			dip_s2_q  <= dip_s1_q;
			dip_s3_q  <= dip_s2_q;
			mode_s1_q <= bacnet_mode_pin;
			mode_s2_q <= mode_s1_q;
			mode_s3_q <= mode_s2_q;
			if (dip_s2_q == dip_s3_q)
				dip_q <= dip_s3_q;
			if (mode_s2_q == mode_s3_q)
				mode_q <= mode_s3_q;
		end
	end

	// Requests wait until the sampled switches have settled.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			settle_q <= 4'h0;
		else if (settle_q != `RSB_SETTLE_CYC)
			settle_q <= settle_q + 4'h1; // [RQ22]
	end

	assign take    = req.valid && req_ready_q;
	assign take_rd = take && (req.func == `RSB_FC_READ_HOLD ||
		req.func == `RSB_FC_READ_INPUT); // [RQ15]
	assign take_wr = take && req.func == `RSB_FC_WRITE_ONE;
	assign count_ok = req.count != 8'h00 && req.count <= `RSB_READ_MAX;
	assign wr_addr_ok = req.wdata[15:8] == 8'h00 && (mode_q ?
		req.wdata[7:0] <= `RSB_BAC_MAX : // [RQ3]
		(req.wdata[7:0] >= `RSB_MB_MIN &&
		req.wdata[7:0] <= `RSB_MB_MAX)); // [RQ2]
	assign wr_frame_ok = req.wdata[15:6] == 10'h000 &&
		req.wdata[`RSB_BAUD_LSB +: 3] <= `RSB_BAUD_MAX &&
		req.wdata[`RSB_PAR_LSB +: 2] != 2'h3; // [RQ8]
	assign word = read_word(ptr_q, snap_q, stat_snap_q);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			RSB_ST_BOOT:
				if (settle_q == `RSB_SETTLE_CYC)
					state_d = RSB_ST_IDLE;
			RSB_ST_IDLE:
				if (take_rd && count_ok)
					state_d = RSB_ST_READ;
			RSB_ST_READ:
				if (!word[16] || left_q == 8'h01)
					state_d = RSB_ST_IDLE;
			default:
				state_d = RSB_ST_BOOT;
		endcase
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			state_q     <= RSB_ST_BOOT;
			req_ready_q <= 1'b0;
		end
		else
		begin
			state_q     <= state_d;
			req_ready_q <= state_d == RSB_ST_IDLE && !take;
		end
	end

	// Words walk up from the first address; address equals number minus one.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			ptr_q  <= 16'h0000;
			left_q <= 8'h00;
		end
		else if (take_rd)
		begin
			ptr_q  <= req.addr; // [RQ16]
			left_q <= req.count;
		end
		else if (state_q == RSB_ST_READ)
		begin
			ptr_q  <= ptr_q + 16'h0001;
			left_q <= left_q - 8'h01;
		end
	end

	// One snapshot per request keeps both float halves from one sample.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			snap_q      <= '0;
			stat_snap_q <= 16'h0000;
		end
		else if (take_rd)
		begin
			stat_snap_q <= status_bits;
			if (critical_error)
				snap_q <= {{7{`RSB_FLT_NAN}}, {7{`RSB_FIX_ERR}}}; // [RQ21]
			else
				snap_q <= meas; // [RQ14] [RQ18]
		end
	end

	// Answers: one word a cycle for reads, one echo or exception otherwise.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			rsp_q <= '0;
		else if (state_q == RSB_ST_READ)
		begin
			if (word[16])
				rsp_q <= {1'b1, left_q == 8'h01, 1'b0,
					word[15:0]}; // [RQ10] [RQ12] [RQ17] [RQ19] [RQ20]
			else
				rsp_q <= {1'b1, 1'b1, 1'b1, `RSB_EXC_ADDR};
		end
		else if (take_rd && !count_ok)
			rsp_q <= {1'b1, 1'b1, 1'b1, `RSB_EXC_VALUE};
		else if (take_wr)
		begin
			if (req.addr == `RSB_ADDR_SET)
				rsp_q <= wr_addr_ok ? {3'h6, req.wdata} :
					{3'h7, `RSB_EXC_VALUE};
			else if (req.addr == `RSB_FRAME_SET)
				rsp_q <= wr_frame_ok ? {3'h6, req.wdata} :
					{3'h7, `RSB_EXC_VALUE};
			else
				rsp_q <= {3'h7, `RSB_EXC_ADDR};
		end
		else if (take && !take_rd)
			rsp_q <= {1'b1, 1'b1, 1'b1, `RSB_EXC_FUNC};
		else
			rsp_q <= '0;
	end

	// Stored node address; out-of-range values are refused and left unchanged.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			addr_q <= `RSB_ADDR_RST; // [RQ2] [RQ3]
		else if (take_wr && req.addr == `RSB_ADDR_SET && wr_addr_ok)
			addr_q <= req.wdata[7:0]; // [RQ9]
	end

	// Stored framing; BACnet overrides parity and stops at the output.
	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			frame_set_q <= {`RSB_BAUD_RST, RSB_PAR_EVEN, 1'b0}; // [RQ8]
		else if (take_wr && req.addr == `RSB_FRAME_SET && wr_frame_ok)
			frame_set_q <= {req.wdata[`RSB_BAUD_LSB +: 3],
				rsb_parity_t'(req.wdata[`RSB_PAR_LSB +: 2]),
				req.wdata[`RSB_STOP_BIT]}; // [RQ9]
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			node_address_q <= `RSB_ADDR_RST;
			frame_q        <= {`RSB_BAUD_RST, RSB_PAR_EVEN, 1'b0};
		end
		else
		begin
			node_address_q <= eff_addr(dip_q, addr_q,
				mode_q); // [RQ1] [RQ4] [RQ5] [RQ6]
			if (mode_q)
				frame_q <= {frame_set_q.baud, RSB_PAR_NONE, 1'b0}; // [RQ7]
			else
				frame_q <= frame_set_q; // [RQ8]
		end
	end

	assign req_ready    = req_ready_q;
	assign rsp          = rsp_q;
	assign node_address = node_address_q;
	assign frame        = frame_q;
	assign bacnet_mode  = mode_q;

	// Text fields are read live, so their check compares against the pins.
	a_dip_zero_stored: assert property // [RQ1]
		(@(posedge mclk) disable iff (reset)
		dip_q == 8'h00 |=> node_address_q == $past(addr_q))
		else $error("Zero switches did not select stored address.");
	a_mb_dip_wins: assert property // [RQ4]
		(@(posedge mclk) disable iff (reset)
		(!mode_q && dip_q != 8'h00) |=> node_address_q ==
		($past(dip_q) > `RSB_MB_MAX ? `RSB_MB_MAX : $past(dip_q)))
		else $error("Modbus switch address not applied.");
	a_bac_bit_eight: assert property // [RQ6]
		(@(posedge mclk) disable iff (reset)
		(mode_q && dip_q != 8'h00) |=>
		node_address_q == {1'b0, $past(dip_q[6:0])})
		else $error("BACnet switch address wrong.");
	a_addr_refused: assert property // [RQ2]
		(@(posedge mclk) disable iff (reset)
		(take_wr && req.addr == `RSB_ADDR_SET && !wr_addr_ok) |=>
		$stable(addr_q) && rsp_q.exc && rsp_q.data == `RSB_EXC_VALUE)
		else $error("Out-of-range address write was not refused.");
	a_bac_frame: assert property // [RQ7]
		(@(posedge mclk) disable iff (reset)
		mode_q |=> frame_q.parity == RSB_PAR_NONE && !frame_q.stop2)
		else $error("BACnet framing not 8N1.");
	a_frame_apply: assert property // [RQ9]
		(@(posedge mclk) disable iff (reset)
		(take_wr && req.addr == `RSB_FRAME_SET && wr_frame_ok) |=>
		frame_set_q.baud == $past(req.wdata[2:0]) ##1
		(mode_q || frame_q == frame_set_q))
		else $error("Framing write not applied.");
	a_read_answer: assert property // [RQ15]
		(@(posedge mclk) disable iff (reset)
		(take_rd && count_ok) |-> ##2 rsp_q.valid ##0
		(rsp_q.exc || !rsp_q.last || $past(req.count, 2) == 8'h01))
		else $error("Read was not answered two cycles after take.");
	a_fw_word: assert property // [RQ11]
		(@(posedge mclk) disable iff (reset)
		(state_q == RSB_ST_READ && ptr_q == `RSB_FW_VER) |=>
		rsp_q.data == {FW_MAJOR, FW_MINOR})
		else $error("Firmware version word wrong.");
	a_crit_nan: assert property // [RQ21]
		(@(posedge mclk) disable iff (reset)
		(take_rd && critical_error) |=> snap_q.flt[0] == `RSB_FLT_NAN &&
		snap_q.fix[6] == `RSB_FIX_ERR)
		else $error("Critical error did not force error values.");
	a_status_word: assert property // [RQ17]
		(@(posedge mclk) disable iff (reset)
		(state_q == RSB_ST_READ && ptr_q == `RSB_STATUS) |=>
		rsp_q.data == stat_snap_q)
		else $error("Status word wrong.");
	a_name_first: assert property // [RQ12]
		(@(posedge mclk) disable iff (reset)
		(state_q == RSB_ST_READ && ptr_q == `RSB_NAME_BASE) |=>
		rsp_q.valid && rsp_q.data == name_text[127:112])
		else $error("First sensor name word wrong.");

	c_float_read: cover property (@(posedge mclk) disable iff (reset)
		take_rd && req.addr == `RSB_FLT_T_C && req.count == 8'h02);
	c_addr_write: cover property (@(posedge mclk) disable iff (reset)
		take_wr && req.addr == `RSB_ADDR_SET && wr_addr_ok);
	c_exception: cover property (@(posedge mclk) disable iff (reset)
		rsp_q.valid && rsp_q.exc);
	c_bac_zero: cover property (@(posedge mclk) disable iff (reset)
		mode_q && dip_q == 8'h80);
	c_text_burst: cover property (@(posedge mclk) disable iff (reset)
		take_rd && req.addr == `RSB_NAME_BASE && req.count == 8'h08);

endmodule : rsb_field_bus_regs
`default_nettype wire

/* File: src/rsb_field_bus_cfg.svh */
// Constants for the field-bus register bank: offsets, fields, resets, counts.
`ifndef RSB_FIELD_BUS_CFG_SVH
`define RSB_FIELD_BUS_CFG_SVH

`define RSB_FC_READ_HOLD   8'h03
`define RSB_FC_READ_INPUT  8'h04
`define RSB_FC_WRITE_ONE   8'h06
`define RSB_EXC_FUNC       16'h0001
`define RSB_EXC_ADDR       16'h0002
`define RSB_EXC_VALUE      16'h0003
`define RSB_READ_MAX       8'h7D

`define RSB_ADDR_SET       16'h0000
`define RSB_FRAME_SET      16'h0001
`define RSB_SERIAL_LAST    16'h0007
`define RSB_FW_VER         16'h0008
`define RSB_NAME_BASE      16'h0009
`define RSB_NAME_LAST      16'h0010
`define RSB_STATUS         16'h0259

`define RSB_FLT_T_C        16'h03EA
`define RSB_FLT_T_F        16'h03EC
`define RSB_FLT_T_K        16'h03F0
`define RSB_FLT_RH         16'h03FC
`define RSB_FLT_TD_C       16'h0450
`define RSB_FLT_TD_F       16'h0452
`define RSB_FLT_TD_K       16'h047A
`define RSB_FIX_T_C        16'h0FA1
`define RSB_FIX_T_F        16'h0FA2
`define RSB_FIX_T_K        16'h0FA4
`define RSB_FIX_RH         16'h0FAA
`define RSB_FIX_TD_C       16'h0FD4
`define RSB_FIX_TD_F       16'h0FD5
`define RSB_FIX_TD_K       16'h0FE9

`define RSB_ADDR_RST       8'h2D
`define RSB_MB_MIN         8'h01
`define RSB_MB_MAX         8'hF7
`define RSB_BAC_MAX        8'h7F
`define RSB_BAUD_RST       3'h0
`define RSB_BAUD_MAX       3'h5
`define RSB_BAUD_LSB       0
`define RSB_PAR_LSB        3
`define RSB_STOP_BIT       5
`define RSB_FLT_NAN        32'h7FC0_0000
`define RSB_FIX_ERR        16'h8000
`define RSB_SETTLE_CYC     4'h6

`endif

/* File: src/rsb_field_bus_pkg.sv */
// Types shared by the field-bus register bank.
package rsb_field_bus_pkg;

	typedef enum logic [1:0]
	{
		RSB_PAR_NONE = 2'h0,
		RSB_PAR_ODD  = 2'h1,
		RSB_PAR_EVEN = 2'h2
	} rsb_parity_t;

	typedef enum logic [1:0]
	{
		RSB_ST_BOOT = 2'h0,
		RSB_ST_IDLE = 2'h1,
		RSB_ST_READ = 2'h3
	} rsb_state_t;

	typedef struct packed {
		logic [2:0]  baud;
		rsb_parity_t parity;
		logic        stop2;
	} rsb_frame_t;

	typedef struct packed {
		logic [6:0][31:0] flt;
		logic [6:0][15:0] fix;
	} rsb_meas_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [7:0]  count;
		logic [15:0] wdata;
	} rsb_req_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic        exc;
		logic [15:0] data;
	} rsb_rsp_t;

endpackage : rsb_field_bus_pkg

/* File: verif/rsb_bus_master.sv */
// Protocol-engine model that issues bank requests and gathers answer words.
`timescale 1ns/1ps
`default_nettype none
module rsb_bus_master
(
	// Clock
	input  wire logic                        mclk,
	// Handshake with the register bank
	input  wire logic                        req_ready,
	input  wire rsb_field_bus_pkg::rsb_rsp_t rsp,
	output rsb_field_bus_pkg::rsb_req_t      req
);
	import rsb_field_bus_pkg::*;
	logic [15:0] wq[$];
	logic        exc_seen;

	initial req = '0;

	task xfer(input logic [7:0] f, input logic [15:0] a,
		input logic [7:0] n, input logic [15:0] w);
		int k;
		wq.delete();
		exc_seen = 1'b0;
		k = 0;
		@(posedge mclk);
		req <= '{1'b1, f, a, n, w};
		// The request stays put until ready is seen ahead of the take edge.
		do
		begin
			@(negedge mclk);
			k++;
		end
		while (req_ready !== 1'b1 && k < 100);
		@(posedge mclk);
		// Released fields show the inverse so stale values cannot pass.
		req <= '{1'b0, ~f, ~a, ~n, ~w};
		k = 0;
		do
		begin
			@(negedge mclk);
			if (rsp.valid === 1'b1)
			begin
				wq.push_back(rsp.data);
				exc_seen |= rsp.exc;
			end
			k++;
		end
		while (!(rsp.valid === 1'b1 && rsp.last === 1'b1) && k < 200);
	endtask : xfer
endmodule : rsb_bus_master
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking testbench for the field-bus register bank.
`timescale 1ns/1ps
`default_nettype none
`include "rsb_field_bus_cfg.svh"
module tb;
	import rsb_field_bus_pkg::*;
	logic         mclk = 1'b0;
	logic         reset = 1'b1;
	logic [7:0]   dip_switch_pin;
	logic         bacnet_mode_pin;
	rsb_meas_t    meas;
	logic [15:0]  status_bits;
	logic         critical_error;
	logic [127:0] serial_text;
	logic [127:0] name_text;
	rsb_req_t     req;
	logic         req_ready;
	rsb_rsp_t     rsp;
	logic [7:0]   node_address;
	rsb_frame_t   frame;
	logic         bacnet_mode;
	int           err_total;
	int           check_count;
	logic [15:0]  fa[7] = '{`RSB_FLT_T_C, `RSB_FLT_T_F, `RSB_FLT_T_K,
		`RSB_FLT_RH, `RSB_FLT_TD_C, `RSB_FLT_TD_F, `RSB_FLT_TD_K};

	always #5 mclk = ~mclk;

	rsb_field_bus_regs #(.FW_MAJOR(8'h12), .FW_MINOR(8'h34)) dut (
		.mclk(mclk), .reset(reset), .dip_switch_pin(dip_switch_pin),
		.bacnet_mode_pin(bacnet_mode_pin), .meas(meas),
		.status_bits(status_bits), .critical_error(critical_error),
		.serial_text(serial_text), .name_text(name_text), .req(req),
		.req_ready(req_ready), .rsp(rsp), .node_address(node_address),
		.frame(frame), .bacnet_mode(bacnet_mode));

	rsb_bus_master master (.mclk(mclk), .req_ready(req_ready), .rsp(rsp),
		.req(req));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
			err_total++;
		end
	endtask : chk

	task close_out;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task done(input string s);
		$display("test %s done", s);
	endtask : done

	task settle(input int n);
		repeat (n) @(negedge mclk);
	endtask : settle

	// Read n words and compare them with the top words of exp.
	task rd(input logic [7:0] f, input logic [15:0] a, input int n,
		input logic [127:0] exp);
		master.xfer(f, a, 8'(n), 16'h0000);
		chk(32'(master.wq.size()), 32'(n));
		for (int k = 0; k < n; k++)
			chk(32'(master.wq[k]), 32'(exp[127 - 16 * k -: 16]));
	endtask : rd

	task wr(input logic [15:0] a, input logic [15:0] w,
		input logic [15:0] code);
		master.xfer(`RSB_FC_WRITE_ONE, a, 8'h01, w);
		chk(32'(master.wq[0]), 32'(code));
		chk(32'(master.exc_seen), 32'(code != w));
	endtask : wr

	initial
	begin
		repeat (5000) @(posedge mclk);
		err_total++;
		close_out;
	end

	initial
	begin
		dip_switch_pin = 8'h00;
		bacnet_mode_pin = 1'b0;
		status_bits = 16'h0005;
		critical_error = 1'b0;
		serial_text = "SN-0123456789ABC";
		name_text = "room-sensor-0001";
		for (int i = 0; i < 7; i++)
		begin
			meas.flt[i] = {16'h4100 + 16'(i), 16'hA500 + 16'(i)};
			meas.fix[i] = 16'h0100 + 16'(i);
		end
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		settle(12);
		chk(32'(req_ready), 32'h0000_0001);
		chk(32'(node_address), 32'h0000_002D);
		chk(32'(frame), 32'({3'h0, RSB_PAR_EVEN, 1'b0}));
		done("reset");
		wr(`RSB_ADDR_SET, 16'h000B, 16'h000B);
		settle(3);
		chk(32'(node_address), 32'h0000_000B);
		wr(`RSB_ADDR_SET, 16'h0000, `RSB_EXC_VALUE);
		wr(`RSB_ADDR_SET, 16'h00F8, `RSB_EXC_VALUE);
		wr(`RSB_ADDR_SET, 16'h00F7, 16'h00F7);
		wr(`RSB_ADDR_SET, 16'h000B, 16'h000B);
		wr(`RSB_FRAME_SET, 16'h002D, 16'h002D);
		settle(3);
		chk(32'(frame), 32'({3'h5, RSB_PAR_ODD, 1'b1}));
		wr(`RSB_FRAME_SET, 16'h0018, `RSB_EXC_VALUE);
		wr(`RSB_FRAME_SET, 16'h0006, `RSB_EXC_VALUE);
		wr(16'h0002, 16'h0001, `RSB_EXC_ADDR);
		settle(3);
		chk(32'(node_address), 32'h0000_000B);
		chk(32'(frame), 32'({3'h5, RSB_PAR_ODD, 1'b1}));
		done("writes");
		@(posedge mclk);
		dip_switch_pin <= 8'h05;
		settle(8);
		chk(32'(node_address), 32'h0000_0005);
		@(posedge mclk);
		dip_switch_pin <= 8'hFF;
		settle(8);
		chk(32'(node_address), 32'h0000_00F7);
		done("switches");
		// Both float halves come in one request so they cannot tear.
		for (int i = 0; i < 7; i++)
			rd(i[0] ? `RSB_FC_READ_INPUT : `RSB_FC_READ_HOLD, fa[i], 2,
				{meas.flt[i], 96'h0});
		rd(`RSB_FC_READ_HOLD, `RSB_FIX_T_C, 1, {meas.fix[0], 112'h0});
		rd(`RSB_FC_READ_INPUT, 16'h0000, 8, serial_text);
		rd(`RSB_FC_READ_HOLD, 16'h0009, 8, name_text);
		rd(`RSB_FC_READ_INPUT, `RSB_FW_VER, 1, {16'h1234, 112'h0});
		rd(`RSB_FC_READ_HOLD, `RSB_STATUS, 1, {16'h0005, 112'h0});
		master.xfer(8'h10, 16'h0000, 8'h01, 16'h0000);
		chk(32'(master.wq[0]), 32'(`RSB_EXC_FUNC));
		master.xfer(`RSB_FC_READ_HOLD, 16'h0300, 8'h01, 16'h0000);
		chk(32'(master.wq[0]), 32'(`RSB_EXC_ADDR));
		done("reads");
		@(posedge mclk);
		critical_error <= 1'b1;
		rd(`RSB_FC_READ_HOLD, `RSB_FLT_TD_K, 2, {`RSB_FLT_NAN, 96'h0});
		rd(`RSB_FC_READ_INPUT, `RSB_FIX_RH, 1, {16'h8000, 112'h0});
		@(posedge mclk);
		critical_error <= 1'b0;
		done("error");
		@(posedge mclk);
		bacnet_mode_pin <= 1'b1;
		dip_switch_pin <= 8'h80;
		settle(8);
		chk(32'(bacnet_mode), 32'h0000_0001);
		chk(32'(node_address), 32'h0000_0000);
		chk(32'(frame), 32'({3'h5, RSB_PAR_NONE, 1'b0}));
		@(posedge mclk);
		dip_switch_pin <= 8'h85;
		settle(8);
		chk(32'(node_address), 32'h0000_0005);
		@(posedge mclk);
		dip_switch_pin <= 8'h00;
		settle(8);
		chk(32'(node_address), 32'h0000_000B);
		wr(`RSB_ADDR_SET, 16'h0080, `RSB_EXC_VALUE);
		wr(`RSB_ADDR_SET, 16'h0000, 16'h0000);
		settle(3);
		chk(32'(node_address), 32'h0000_0000);
		done("bacnet");
		close_out;
	end
endmodule : tb
`default_nettype wire
